// File: logic/spi_nv_pkg.sv
package spi_nv_pkg;

   // ------------------------------------------------
   // Array geometry
   // ------------------------------------------------
   localparam int              ADDR_W    = 17;
   localparam int              MEM_BYTES = 131072;
   localparam logic [16:0]     QUARTER   = 17'h1_8000;
   localparam logic [16:0]     HALF      = 17'h1_0000;

   // ------------------------------------------------
   // Opcodes
   // ------------------------------------------------
   localparam logic [7:0] OP_STATUS_READ  = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_LATCH_SET    = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
   localparam logic [7:0] OP_READ         = 8'h03;
   localparam logic [7:0] OP_FAST_READ    = 8'h0B;
   localparam logic [7:0] OP_WRITE        = 8'h02;
   localparam logic [7:0] OP_CLOCK_WRITE  = 8'h12;
   localparam logic [7:0] OP_SERIAL_WRITE = 8'hC2;
   localparam logic [7:0] OP_SAVE         = 8'h3C;
   localparam logic [7:0] OP_RESTORE      = 8'h60;
   localparam logic [7:0] OP_AUTOSAVE_ON  = 8'h59;
   localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;

   // ------------------------------------------------
   // protection_status fields and frame counts
   // ------------------------------------------------
   localparam int         SR_BUSY        = 0;
   localparam int         SR_LATCH       = 1;
   localparam int         SR_GUARD_LO    = 2;
   localparam int         SR_GUARD_HI    = 3;
   localparam int         SR_LOCK        = 6;
   localparam int         SR_PIN_EN      = 7;
   localparam logic [7:0] SR_RESET       = 8'h00;
   localparam logic [5:0] ADDR_LAST_BIT  = 6'h1F;
   localparam logic [5:0] DUMMY_LAST_BIT = 6'h27;

   // ------------------------------------------------
   // Types
   // ------------------------------------------------
   typedef enum logic [1:0] {NV_SAVE, NV_RESTORE, NV_AUTO_ON, NV_AUTO_OFF} nvKind_t;

   typedef struct packed {
      logic    valid;
      nvKind_t kind;
   } nvReq_t;

   typedef struct packed {
      logic       pinGuardEnable;
      logic       serialLock;
      logic [1:0] blockGuard;
      logic       writeLatch;
   } guardState_t;

   typedef enum {
      ST_OPCODE, ST_ADDRESS, ST_DUMMY, ST_MEM_READ,
      ST_MEM_WRITE, ST_STATUS_READ, ST_STATUS_WRITE, ST_IGNORE
   } frameState_t;

endpackage

// File: logic/spi_nv_target.sv
module spi_nv_target
   import spi_nv_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic sck,
   input  wire logic csN,
   input  wire logic mosi,
   input  wire logic guardN,
   input  wire logic saveBusyN,
   output logic      miso,
   output logic      misoOeN,
   output nvReq_t    nvReq
);

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------

   // Guarded range lookup for the two block guard bits
   function automatic logic isGuarded(input logic [16:0] a,
                                      input logic [1:0]  g);
      logic r;
      r = 1'b0;
      case (g)
         2'b01:   r = (a >= QUARTER);
         2'b10:   r = (a >= HALF);
         2'b11:   r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------
   // Declarations
   // ------------------------------------------------
   logic             rstMeta_q;
   logic             rstN_q;
   logic             guardMeta_q;
   logic             guardSync_q;
   logic             busyMeta_q;
   logic             busySync_q;
   logic             frameClr;
   logic [5:0]       bitCnt_q;
   logic [7:0]       shiftIn_q;
   logic [7:0]       shiftNext;
   logic             byteDone;
   frameState_t      state_q;
   frameState_t      after_q;
   logic [16:0]      addr_q;
   logic             guardHeld_q;
   guardState_t      prot_q;
   logic             latchClrPend_q;
   logic             latchEff;
   logic [7:0]       statusByte;
   logic             nvTgl_q;
   nvKind_t          nvKind_q;
   logic             nvMeta_q;
   logic             nvSync_q;
   logic             nvSeen_q;
   nvReq_t           nvReq_q;
   logic [7:0]       mem [0:MEM_BYTES-1];
   logic [7:0]       loadByte;
   logic [7:0]       outShift_q;
   logic             miso_q;
   logic             misoOeN_q;
   frameState_t      opState;
   frameState_t      opAfter;
   logic             opLatchSet;
   logic             opLatchUse;
   logic             opNv;
   nvKind_t          opNvKind;

   // ------------------------------------------------
   // Reset release
   // ------------------------------------------------

   // Async assert, release through two flops on clk
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end

   // ------------------------------------------------
   // Pin synchronisers on the link clock
   // ------------------------------------------------

   // The link clock idles between frames, so these values
   // may lag by one frame for its first edges; the opcode
   // byte gives them seven edges to settle before use.
   always_ff @(posedge sck or negedge rstN_q) begin
      if (!rstN_q) begin
         guardMeta_q <= 1'b1;
         guardSync_q <= 1'b1;
         busyMeta_q  <= 1'b1;
         busySync_q  <= 1'b1;
      end else begin
         guardMeta_q <= guardN;
         guardSync_q <= guardMeta_q;
         busyMeta_q  <= saveBusyN;
         busySync_q  <= busyMeta_q;
      end
   end

   // ------------------------------------------------
   // Shared frame terms
   // ------------------------------------------------

   // Deselect or power reset clears all frame state
   assign frameClr   = csN | ~rstN_q;
   assign shiftNext  = {shiftIn_q[6:0], mosi};
   assign byteDone   = (bitCnt_q[2:0] == 3'h7);
   // A pending clear is already visible to readers
   assign latchEff   = prot_q.writeLatch & ~latchClrPend_q;
   assign statusByte = {prot_q.pinGuardEnable, prot_q.serialLock, 2'b00,
                        prot_q.blockGuard, latchEff, ~busySync_q};
   assign loadByte   = (state_q == ST_MEM_READ) ? mem[addr_q] : statusByte;

   // ------------------------------------------------
   // Opcode decode
   // ------------------------------------------------

   // Decided on the eighth rising edge of the frame
   always_comb begin
      opState    = ST_IGNORE;
      opAfter    = ST_MEM_READ;
      opLatchSet = 1'b0;
      opLatchUse = 1'b0;
      opNv       = 1'b0;
      opNvKind   = NV_SAVE;
      case (shiftNext)
         OP_LATCH_SET: begin
            opLatchSet = 1'b1;
         end
         OP_LATCH_CLEAR: begin
            opLatchUse = 1'b1;
         end
         OP_STATUS_READ: begin
            opState = ST_STATUS_READ;
         end
         OP_STATUS_WRITE: begin
            if (latchEff) begin
               opState = ST_STATUS_WRITE;
            end
         end
         OP_READ: begin
            if (busySync_q) begin
               opState = ST_ADDRESS;
            end
         end
         OP_FAST_READ: begin
            if (busySync_q) begin
               opState = ST_ADDRESS;
               opAfter = ST_DUMMY;
            end
         end
         OP_WRITE: begin
            if (busySync_q && latchEff) begin
               opState    = ST_ADDRESS;
               opAfter    = ST_MEM_WRITE;
               opLatchUse = 1'b1;
            end
         end
         OP_CLOCK_WRITE, OP_SERIAL_WRITE: begin
            opLatchUse = latchEff;
         end
         OP_SAVE, OP_RESTORE, OP_AUTOSAVE_ON, OP_AUTOSAVE_OFF: begin
            opLatchUse = latchEff;
            opNv       = latchEff;
            case (shiftNext)
               OP_SAVE:        opNvKind = NV_SAVE;
               OP_RESTORE:     opNvKind = NV_RESTORE;
               OP_AUTOSAVE_ON: opNvKind = NV_AUTO_ON;
               default:        opNvKind = NV_AUTO_OFF;
            endcase
         end
         default: begin
            opState = ST_IGNORE;
         end
      endcase
   end

   // ------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------

   // Counts rising edges and walks the frame phases
   always_ff @(posedge sck or posedge frameClr) begin
      if (frameClr) begin
         bitCnt_q    <= 6'h00;
         shiftIn_q   <= 8'h00;
         state_q     <= ST_OPCODE;
         after_q     <= ST_MEM_READ;
         addr_q      <= 17'h0_0000;
         guardHeld_q <= 1'b0;
      end else begin
         bitCnt_q  <= bitCnt_q + 6'h01;
         shiftIn_q <= shiftNext;
         case (state_q)
            ST_OPCODE: begin
               if (byteDone) begin
                  state_q     <= opState;
                  after_q     <= opAfter;
                  guardHeld_q <= ~guardSync_q;
               end
            end
            ST_ADDRESS: begin
               // Only the low 17 bits survive, so A16 lands in bit 16
               addr_q <= {addr_q[ADDR_W-2:0], mosi};
               if (bitCnt_q == ADDR_LAST_BIT) begin
                  state_q <= after_q;
               end
            end
            ST_DUMMY: begin
               if (bitCnt_q == DUMMY_LAST_BIT) begin
                  state_q <= ST_MEM_READ;
               end
            end
            ST_MEM_READ, ST_MEM_WRITE: begin
               if (byteDone) begin
                  addr_q <= addr_q + 17'h0_0001;
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // ------------------------------------------------
   // protection_status register
   // ------------------------------------------------

   // Plain flops: nothing here survives power loss, a save
   // request below is the only way the value is kept.
   always_ff @(posedge sck or negedge rstN_q) begin
      if (!rstN_q) begin
         prot_q         <= guardState_t'({SR_RESET[SR_PIN_EN], SR_RESET[SR_LOCK],
                                          SR_RESET[SR_GUARD_HI:SR_GUARD_LO], SR_RESET[SR_LATCH]});
         latchClrPend_q <= 1'b0;
      end else begin
         if (state_q == ST_OPCODE && bitCnt_q == 6'h00 && latchClrPend_q) begin
            prot_q.writeLatch <= 1'b0;
            latchClrPend_q    <= 1'b0;
         end
         if (state_q == ST_OPCODE && byteDone) begin
            if (opLatchSet) begin
               prot_q.writeLatch <= 1'b1;
            end
            if (opLatchUse) begin
               latchClrPend_q <= 1'b1;
            end
         end
         if (state_q == ST_STATUS_WRITE && byteDone) begin
            latchClrPend_q <= 1'b1;
            if (!(prot_q.pinGuardEnable && guardHeld_q)) begin
               prot_q.pinGuardEnable <= shiftNext[SR_PIN_EN];
               prot_q.serialLock     <= prot_q.serialLock | shiftNext[SR_LOCK];
               prot_q.blockGuard     <= shiftNext[SR_GUARD_HI:SR_GUARD_LO];
            end
         end
      end
   end

   // ------------------------------------------------
   // Memory array
   // ------------------------------------------------

   // Guarded bytes are skipped but the address still moves
   always_ff @(posedge sck) begin
      if (state_q == ST_MEM_WRITE && byteDone && !isGuarded(addr_q, prot_q.blockGuard)) begin
         mem[addr_q] <= shiftNext;
      end
   end

   // ------------------------------------------------
   // Serial output
   // ------------------------------------------------

   // Falling edges shift out; deselect releases at once
   always_ff @(negedge sck or posedge frameClr) begin
      if (frameClr) begin
         miso_q     <= 1'b0;
         misoOeN_q  <= 1'b1;
         outShift_q <= 8'h00;
      end else if (state_q == ST_MEM_READ || state_q == ST_STATUS_READ) begin
         misoOeN_q <= 1'b0;
         if (bitCnt_q[2:0] == 3'h0) begin
            miso_q     <= loadByte[7];
            outShift_q <= {loadByte[6:0], 1'b0};
         end else begin
            miso_q     <= outShift_q[7];
            outShift_q <= {outShift_q[6:0], 1'b0};
         end
      end
   end

   // ------------------------------------------------
   // Save request crossing
   // ------------------------------------------------

   // Toggle marks a request; the kind is held until the next
   // one, which is a whole frame away, so it is stable here.
   always_ff @(posedge sck or negedge rstN_q) begin
      if (!rstN_q) begin
         nvTgl_q  <= 1'b0;
         nvKind_q <= NV_SAVE;
      end else if (state_q == ST_OPCODE && byteDone && opNv) begin
         nvTgl_q  <= ~nvTgl_q;
         nvKind_q <= opNvKind;
      end
   end

   // Toggle to one-cycle pulse on the system clock
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         nvMeta_q <= 1'b0;
         nvSync_q <= 1'b0;
         nvSeen_q <= 1'b0;
         nvReq_q  <= '0;
      end else begin
         nvMeta_q      <= nvTgl_q;
         nvSync_q      <= nvMeta_q;
         nvSeen_q      <= nvSync_q;
         nvReq_q.valid <= nvSync_q ^ nvSeen_q;
         nvReq_q.kind  <= nvKind_q;
      end
   end

   // ------------------------------------------------
   // Outputs
   // ------------------------------------------------
   assign miso    = miso_q;
   assign misoOeN = misoOeN_q;
   assign nvReq   = nvReq_q;

endmodule

// File: verif/spi_host_model.sv
module spi_host_model (
   output logic      sck,
   output logic      csN,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic misoOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------
   // Mode 0 controller, 6.25 MHz link
   // ------------------------------------
   localparam int HALF_NS = 80;
   logic [7:0] rxq [$];
   logic       oeSeen;
   // Link idles with clock low and deselected
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      mosi = 1'b1;
      oeSeen = 1'b0;
   end
   // Sends all bytes MSB first, then clocks in nrx bytes
   task automatic frame(input logic [7:0] tx [$], input int nrx);
      logic [7:0] b;
      logic [7:0] r;
      rxq = {};
      oeSeen = 1'b0;
      csN = 1'b0;
      #HALF_NS;
      for (int i = 0; i < tx.size() + nrx; i++) begin
         b = (i < tx.size()) ? tx[i] : 8'hFF;
         for (int k = 7; k >= 0; k--) begin
            mosi = b[k];
            #HALF_NS sck = 1'b1;
            r = {r[6:0], miso};
            if (misoOeN === 1'b0) oeSeen = 1'b1;
            #HALF_NS sck = 1'b0;
         end
         if (i >= tx.size()) rxq.push_back(r);
      end
      #HALF_NS csN = 1'b1;
      mosi = ~mosi;
      #(4 * HALF_NS);
   endtask
endmodule

// File: verif/spi_nv_monitor.sv
module spi_nv_monitor
   import spi_nv_pkg::*;
(
   input wire logic   clk,
   input wire logic   resetn,
   input wire logic   sck,
   input wire logic   csN,
   input wire logic   miso,
   input wire logic   misoOeN,
   input wire nvReq_t nvReq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------
   // Pin checks on the system clock
   // ------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Frame phases as seen at the pins
   sequence sDeselected;
      csN ##1 csN;
   endsequence
   sequence sDriving;
      !misoOeN && !csN;
   endsequence
   chk_oe_idle: assert property (sDeselected |-> misoOeN)
      else $error("miso enabled while deselected");
   chk_miso_quiet: assert property (misoOeN [*2] |-> !miso)
      else $error("miso not low while released");
   chk_oe_holds: assert property (sDriving ##1 !csN |-> !misoOeN)
      else $error("miso released inside a frame");
   chk_oe_release: assert property ($rose(misoOeN) |-> csN)
      else $error("miso released without deselect");
   chk_oe_start: assert property ($fell(misoOeN) |-> !csN && !sck)
      else $error("miso enabled off a falling edge");
   chk_miso_edge: assert property (!csN && sck && $past(sck) |-> $stable(miso))
      else $error("miso moved while clock high");
   chk_req_pulse: assert property (nvReq.valid |=> !nvReq.valid)
      else $error("store request too long");
   // Reset must silence outputs, so this one is never disabled
   chk_reset_quiet: assert property (disable iff (1'b0) !resetn |-> misoOeN && !nvReq.valid)
      else $error("outputs active in reset");
endmodule

bind spi_nv_target spi_nv_monitor i_mon (.clk(clk), .resetn(resetn), .sck(sck), .csN(csN),
   .miso(miso), .misoOeN(misoOeN), .nvReq(nvReq));

// File: verif/testbench.sv
module testbench
   import spi_nv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------
   // Stimulus and checking
   // ------------------------------------
   typedef struct packed {
      logic        latch;
      logic [23:0] wrAddr;
      logic [7:0]  wrData;
      logic [23:0] rdAddr;
      logic [7:0]  rdData;
   } row_t;
   logic        clk, resetn, guardN, saveBusyN, sck, csN, mosi, miso, misoOeN;
   nvReq_t      nvReq;
   int          num_errors, n_checks, reqCount;
   nvKind_t     lastKind;
   logic [7:0]  pat [6];
   logic [7:0]  tx [$];
   logic [16:0] base [3] = '{17'h0_FFFF, 17'h1_7FFF, 17'h1_FFFF};
   logic [7:0]  nvOps [4] = '{OP_SAVE, OP_RESTORE, OP_AUTOSAVE_ON, OP_AUTOSAVE_OFF};
   row_t        rows [4] = '{'{1'b1, 24'h00_0010, 8'hA5, 24'h00_0010, 8'hA5},
                             '{1'b1, 24'h00_0100, 8'h12, 24'h00_0100, 8'h12},
                             '{1'b0, 24'h00_0100, 8'h3C, 24'h00_0100, 8'h12},
                             '{1'b1, 24'hFF_0020, 8'h6B, 24'h01_0020, 8'h6B}};

   spi_nv_target i_dut (.clk(clk), .resetn(resetn), .sck(sck), .csN(csN), .mosi(mosi), .guardN(guardN),
      .saveBusyN(saveBusyN), .miso(miso), .misoOeN(misoOeN), .nvReq(nvReq));
   spi_host_model i_host (.sck(sck), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN));

   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Store requests are one-cycle pulses, so count them here
   always @(posedge clk) begin
      if (nvReq.valid === 1'b1) begin
         reqCount++;
         lastKind = nvReq.kind;
      end
   end
   // Hang guard, well beyond the sequence length
   initial begin
      #2000000;
      num_errors++;
      end_sim();
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Frames start off the system clock's falling edge
   task automatic xfer(input logic [7:0] q [$], input int nrx);
      @(negedge clk);
      i_host.frame(q, nrx);
      // Hand back on a falling edge so pin changes keep that rhythm
      @(negedge clk);
   endtask
   task automatic op(input logic [7:0] c);
      xfer({c}, 0);
   endtask
   task automatic scheck(input logic [7:0] exp);
      xfer({OP_STATUS_READ}, 1);
      check("status", i_host.rxq[0], exp);
   endtask
   task automatic swrite(input logic [7:0] v);
      op(OP_LATCH_SET);
      xfer({OP_STATUS_WRITE, v}, 0);
   endtask
   task automatic mwrite(input logic [23:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n,
                         input logic en);
      if (en) begin
         op(OP_LATCH_SET);
      end
      tx = {OP_WRITE, a[23:16], a[15:8], a[7:0], d0};
      if (n > 1) tx.push_back(d1);
      xfer(tx, 0);
   endtask
   task automatic mread(input logic [23:0] a, input int n, input logic fast);
      tx = {fast ? OP_FAST_READ : OP_READ, a[23:16], a[15:8], a[7:0]};
      if (fast) tx.push_back(8'h00);
      xfer(tx, n);
   endtask
   function automatic logic prot(input int g, input logic [16:0] a);
      return g == 3 || (g == 2 && a >= HALF) || (g == 1 && a >= QUARTER);
   endfunction

   // Main sequence
   initial begin
      resetn = 1'b0;
      guardN = 1'b1;
      saveBusyN = 1'b1;
      num_errors = 0;
      n_checks = 0;
      reqCount = 0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      foreach (rows[i]) begin
         mwrite(rows[i].wrAddr, rows[i].wrData, 8'h00, 1, rows[i].latch);
         mread(rows[i].rdAddr, 1, 1'b0);
         check("read", i_host.rxq[0], rows[i].rdData);
      end
      $display("test table done");
      resetn = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      scheck(8'h00);
      op(OP_LATCH_SET);
      scheck(8'h02);
      op(8'h1E);
      scheck(8'h02);
      op(OP_LATCH_CLEAR);
      scheck(8'h00);
      $display("test latch done");
      swrite(8'hB3);
      scheck(8'h80);
      guardN = 1'b0;
      swrite(8'h0C);
      scheck(8'h80);
      guardN = 1'b1;
      // Guard pin falls after the opcode of the status write frame
      fork
         swrite(8'h84);
         begin
            @(negedge csN);
            @(negedge csN);
            repeat (64) @(negedge clk);
            guardN = 1'b0;
         end
      join
      scheck(8'h84);
      swrite(8'h00);
      scheck(8'h84);
      guardN = 1'b1;
      swrite(8'h00);
      guardN = 1'b0;
      swrite(8'h04);
      scheck(8'h04);
      guardN = 1'b1;
      $display("test pin guard done");
      for (int g = 0; g < 4; g++) begin
         swrite(8'(g << 2));
         for (int k = 0; k < 3; k++) begin
            mwrite({7'h00, base[k]}, 8'(16 * g + 2 * k), 8'(16 * g + 2 * k + 1), 2, 1'b1);
            for (int j = 0; j < 2; j++) begin
               if (!prot(g, base[k] + 17'(j))) pat[2 * k + j] = 8'(16 * g + 2 * k + j);
            end
         end
         for (int k = 0; k < 3; k++) begin
            mread({7'h00, base[k]}, 2, 1'b1);
            check("guard first", i_host.rxq[0], pat[2 * k]);
            check("guard next", i_host.rxq[1], pat[2 * k + 1]);
         end
      end
      $display("test block guard done");
      swrite(8'h40);
      swrite(8'h00);
      scheck(8'h40);
      saveBusyN = 1'b0;
      scheck(8'h41);
      mwrite(24'h00_0100, 8'h55, 8'h00, 1, 1'b1);
      mread(24'h00_0100, 1, 1'b0);
      check("busy drive", {7'h00, i_host.oeSeen}, 8'h00);
      saveBusyN = 1'b1;
      op(OP_LATCH_CLEAR);
      mread(24'h00_0100, 1, 1'b0);
      check("busy read", i_host.rxq[0], 8'h12);
      $display("test busy done");
      foreach (nvOps[i]) begin
         op(OP_LATCH_SET);
         op(nvOps[i]);
         repeat (8) @(negedge clk);
         check("req count", 8'(reqCount), 8'(i + 1));
         check("req kind", 8'(lastKind), 8'(i));
         scheck(8'h40);
      end
      op(OP_SAVE);
      repeat (8) @(negedge clk);
      check("req count", 8'(reqCount), 8'h04);
      $display("test store done");
      end_sim();
   end
endmodule
